// *** src/pbs_sram.sv ***
// Pipelined burst synchronous SRAM core, device side of the pins.
// Assumes pins come from the bus master's clock domain; oe_n and sleep are asynchronous.
// Summary of operation
// RQ1: All synchronous inputs are captured in registers on the rising clock edge.
// RQ2: Read data passes through an output register, one pipeline stage.
// RQ3: Address and chip selects load only when an address strobe is asserted.
// RQ4: Array holds 524288 words of 32 bits.
// RQ5: Two-bit wrapping burst counter starts at address, steps on burst step.
// RQ6: Burst order chosen by sampling the order select input.
// RQ7: Order select high: interleaved, start low bits XOR beat count.
// RQ8: Order select low: linear, low bits increment and wrap.
// RQ9: Master asserts burst step low at clock rise; counter advances.
// RQ10: Three chip selects, primary and third low, second high; all needed.
// RQ11: Processor strobe ignored while primary chip select is high.
// RQ12: Read starts on strobe, all selects active, write controls high.
// RQ13: Read address latched, data driven after next edge if output enable low.
// RQ14: First cycle after deselect keeps outputs off; then output enable rules.
// RQ15: Back-to-back reads; outputs off right after a deselecting edge.
// RQ16: Processor-strobe start ignores write controls and burst step that cycle.
// RQ17: Processor-strobe write completes at the second clock rise.
// RQ18: Global write low writes all four bytes.
// RQ19: Byte-write gate low writes only selected lanes; others unchanged.
// RQ20: Master raises output enable before driving write data.
// RQ21: Data drivers off when a strobe-started write cycle is detected; writes during a burst step do not cut them.
// RQ22: Output enable and sleep act asynchronously, not registered.
// RQ23: Sleep entry and exit take four clocks from the pin, two synchroniser stages then two states; master deselects first.
// RQ24: Four-beat burst delivered 3-1-1-1.
// RQ25: No strobe and no burst step holds the burst address.
`timescale 1ns/100ps
`default_nettype none
`include "pbs_defs.svh"
module pbs_sram #(
  parameter int ADDR_W = `PBS_ADDR_W,
  parameter int DATA_W = `PBS_DATA_W,
  parameter int LANES = `PBS_LANES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire pbs_pkg::pbs_ctrl_t ctrl_i,
  input wire logic burst_order_i,
  input wire logic output_en_n_i,
  input wire logic sleep_request_i,
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic asleep_o
);
  localparam int BW = `PBS_BURST_W;
  // Input registers: pins are from the master's clock, one stage here
  pbs_pkg::pbs_ctrl_t ctrl_reg, ctrl_next;
  logic [ADDR_W-1:0] addr_in_reg, addr_in_next;
  logic [DATA_W-1:0] din_reg, din_next;
  logic order_reg, order_next;
  // Access state
  logic [ADDR_W-1:0] base_reg, base_next;
  logic [BW-1:0] beat_reg, beat_next;
  logic sel_reg, sel_next;
  logic wpend_reg, wpend_next;
  logic rd_reg, rd_next;
  logic first_reg, first_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic rvalid_reg, rvalid_next;
  logic rfirst_reg, rfirst_next;
  // Sleep path: asynchronous pin, synchronised before the sleep state machine; driver enable uses the raw pin
  logic [1:0] zz_sync_reg, zz_sync_next;
  pbs_pkg::pbs_sleep_t sleep_reg, sleep_next;

  logic [ADDR_W-1:0] mem_addr;
  logic [LANES-1:0] mem_we;
  logic [DATA_W-1:0] mem_rdata;
  logic selected, strobe, proc_start, ctrl_start, step, is_write;
  logic [LANES-1:0] lanes_w;

  // Burst address from start address and beat count
  function automatic logic [BW-1:0] burst_addr(input logic [BW-1:0] start,
    input logic [BW-1:0] beat, input logic interleaved);
    if (interleaved)
      burst_addr = start ^ beat; // [RQ7]
    else
      burst_addr = start + beat; // [RQ8]
  endfunction

  // Byte lanes written by the current write controls
  function automatic logic [LANES-1:0] write_lanes(input pbs_pkg::pbs_ctrl_t c);
    if (!c.global_write_n)
      write_lanes = '1; // [RQ18]
    else if (!c.byte_write_gate_n)
      write_lanes = ~c.byte_lane_sel_n; // [RQ19]
    else
      write_lanes = '0;
  endfunction

  always_comb
  begin
    ctrl_next = ctrl_i; // [RQ1]
    addr_in_next = addr_i; // [RQ1]
    din_next = dq_i; // [RQ1]
    order_next = burst_order_i; // [RQ6]
    zz_sync_next = {zz_sync_reg[0], sleep_request_i};
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= '1;
      addr_in_reg <= '0;
      din_reg <= '0;
      order_reg <= 1'b1;
      zz_sync_reg <= `PBS_SYNC_ZERO;
    end
    else if (ce_i)
    begin
      ctrl_reg <= ctrl_next;
      addr_in_reg <= addr_in_next;
      din_reg <= din_next;
      order_reg <= order_next;
      zz_sync_reg <= zz_sync_next;
    end
  end

  // Decode of the registered inputs
  always_comb
  begin
    selected = !ctrl_reg.chip_sel_primary_n && ctrl_reg.chip_sel_depth_hi
      && !ctrl_reg.chip_sel_depth_n; // [RQ10]
    proc_start = !ctrl_reg.processor_addr_strobe_n && !ctrl_reg.chip_sel_primary_n; // [RQ11]
    ctrl_start = !ctrl_reg.controller_addr_strobe_n;
    strobe = proc_start || ctrl_start; // [RQ3]
    lanes_w = write_lanes(ctrl_reg);
    step = !strobe && !ctrl_reg.burst_step_n && sel_reg; // [RQ9]
    is_write = ctrl_start && !proc_start && selected && (lanes_w != '0);
  end

  // Access sequencing; sleep drops every pending access
  always_comb
  begin
    base_next = base_reg;
    beat_next = beat_reg;
    sel_next = sel_reg;
    wpend_next = 1'b0;
    rd_next = 1'b0;
    first_next = 1'b0;
    mem_addr = {base_reg[ADDR_W-1:BW], burst_addr(base_reg[BW-1:0], beat_reg, order_reg)};
    mem_we = '0;
    if (sleep_reg != pbs_pkg::PBS_AWAKE)
    begin
      sel_next = 1'b0; // [RQ23]
    end
    else if (strobe)
    begin
      sel_next = selected; // [RQ3]
      first_next = selected && !sel_reg; // [RQ14]
      if (selected)
      begin
        base_next = addr_in_reg; // [RQ5]
        beat_next = '0;
        mem_addr = addr_in_reg;
        if (proc_start)
        begin
          // Write controls and step ignored; decided at the next edge
          wpend_next = 1'b1; // [RQ16]
          rd_next = 1'b1;
        end
        else if (is_write)
          mem_we = lanes_w; // [RQ19]
        else
          rd_next = 1'b1; // [RQ12]
      end
    end
    else if (wpend_reg && lanes_w != '0)
    begin
      mem_we = lanes_w; // [RQ17]
      // A write second cycle cancels the speculative read
    end
    else if (sel_reg)
    begin
      if (step)
      begin
        beat_next = beat_reg + `PBS_BURST_ONE; // [RQ5]
        mem_addr = {base_reg[ADDR_W-1:BW],
          burst_addr(base_reg[BW-1:0], beat_next, order_reg)};
      end
      // Otherwise the burst address holds [RQ25]
      if (lanes_w != '0 && !ctrl_reg.burst_step_n)
        mem_we = lanes_w;
      else
        rd_next = 1'b1; // [RQ24]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      base_reg <= '0;
      beat_reg <= '0;
      sel_reg <= 1'b0;
      wpend_reg <= 1'b0;
      rd_reg <= 1'b0;
      first_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      base_reg <= base_next;
      beat_reg <= beat_next;
      sel_reg <= sel_next;
      wpend_reg <= wpend_next;
      rd_reg <= rd_next;
      first_reg <= first_next;
    end
  end

  pbs_mem #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W),
    .LANES(LANES)
  ) u_mem (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .addr_i(mem_addr),
    .we_i(mem_we),
    .wdata_i(din_reg),
    .rdata_o(mem_rdata)
  ); // [RQ4]

  // Output register stage
  always_comb
  begin
    dout_next = dout_reg;
    rvalid_next = 1'b0;
    rfirst_next = 1'b0;
    if (rd_reg && !(wpend_reg && lanes_w != '0))
    begin
      dout_next = mem_rdata; // [RQ2]
      rvalid_next = sel_reg; // [RQ15]
      rfirst_next = first_reg;
    end
    if (!sel_next)
      rvalid_next = 1'b0; // [RQ15]
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dout_reg <= '0;
      rvalid_reg <= 1'b0;
      rfirst_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      dout_reg <= dout_next;
      rvalid_reg <= rvalid_next;
      rfirst_reg <= rfirst_next;
    end
  end

  // Sleep takes two clocks each way
  always_comb
  begin
    case (sleep_reg)
      pbs_pkg::PBS_AWAKE: sleep_next = zz_sync_reg[1] ? pbs_pkg::PBS_ENTER : pbs_pkg::PBS_AWAKE;
      pbs_pkg::PBS_ENTER: sleep_next = zz_sync_reg[1] ? pbs_pkg::PBS_ASLEEP : pbs_pkg::PBS_AWAKE;
      pbs_pkg::PBS_ASLEEP: sleep_next = zz_sync_reg[1] ? pbs_pkg::PBS_ASLEEP : pbs_pkg::PBS_LEAVE;
      pbs_pkg::PBS_LEAVE: sleep_next = pbs_pkg::PBS_AWAKE; // [RQ23]
      default: sleep_next = pbs_pkg::PBS_AWAKE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      sleep_reg <= pbs_pkg::PBS_AWAKE;
    else if (ce_i)
      sleep_reg <= sleep_next;
  end

  // Driver enable is combinational on output enable and sleep, so both act at once
  always_comb
  begin
    dq_o = dout_reg;
    // A deselecting edge must cut the drivers at once, not one edge later
    dq_oe_o = rvalid_reg && !rfirst_reg && !output_en_n_i // [RQ13] [RQ14] [RQ22]
      && !(strobe && !selected) // [RQ15]
      && !sleep_request_i && !wpend_reg && !is_write; // [RQ21]
    asleep_o = (sleep_reg == pbs_pkg::PBS_ASLEEP);
  end
endmodule
`default_nettype wire

// *** src/pbs_defs.svh ***
// Constants for the pipelined burst SRAM model.
// Assumes inclusion by bare name; definitions only.
`ifndef PBS_DEFS_SVH
`define PBS_DEFS_SVH
`define PBS_ADDR_W 19
`define PBS_DATA_W 32
`define PBS_LANES 4
`define PBS_LANE_W 8
`define PBS_BURST_W 2
`define PBS_WORDS 524288
`define PBS_SLEEP_CYC 2
`define PBS_BURST_ONE 2'h1
`define PBS_SYNC_ZERO 2'h0
`endif

// *** src/pbs_pkg.sv ***
// Types for the pipelined burst SRAM model.
// Assumes pbs_defs.svh is on the include path.
`include "pbs_defs.svh"
package pbs_pkg;
  typedef struct packed {
    logic chip_sel_primary_n;
    logic chip_sel_depth_hi;
    logic chip_sel_depth_n;
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_step_n;
    logic byte_write_gate_n;
    logic global_write_n;
    logic [`PBS_LANES-1:0] byte_lane_sel_n;
  } pbs_ctrl_t;
  typedef enum logic [1:0] {PBS_AWAKE, PBS_ENTER, PBS_ASLEEP, PBS_LEAVE} pbs_sleep_t;
endpackage

// *** src/pbs_mem.sv ***
// Word memory with per-lane write enables and a registered read port.
// Assumes one clock; contents have no reset.
`timescale 1ns/100ps
`default_nettype none
`include "pbs_defs.svh"
module pbs_mem #(
  parameter int ADDR_W = `PBS_ADDR_W,
  parameter int DATA_W = `PBS_DATA_W,
  parameter int LANES = `PBS_LANES
) (
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [LANES-1:0] we_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic [DATA_W-1:0] rdata_o
);
  localparam int LW = DATA_W / LANES;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : lane
      always_ff @(posedge clk_i)
      begin
        if (ce_i && we_i[g])
          mem[addr_i][g*LW +: LW] <= wdata_i[g*LW +: LW];
      end
    end
  endgenerate
  // Read data registered; feeds the output register stage
  always_ff @(posedge clk_i)
  begin
    if (ce_i)
      rdata_o <= mem[addr_i];
  end
endmodule
`default_nettype wire

// *** verif/pbs_sram_assertions.sv ***
// Pin checker for pbs_sram.
// Assumes binding into pbs_sram; one clock.
`timescale 1ns/100ps
`default_nettype none
module pbs_sram_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire pbs_pkg::pbs_ctrl_t ctrl_i,
  input wire logic output_en_n_i,
  input wire logic sleep_request_i,
  input wire logic [31:0] dq_o,
  input wire logic dq_oe_o,
  input wire logic asleep_o
);
  logic sel;
  assign sel = !ctrl_i.chip_sel_primary_n && ctrl_i.chip_sel_depth_hi && !ctrl_i.chip_sel_depth_n;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  oe_off_a: assert property (output_en_n_i |-> !dq_oe_o)
    else $error("drive with enable off");
  sleep_quiet_a: assert property (asleep_o |-> !dq_oe_o)
    else $error("drive while asleep");
  write_tri_a: assert property (sel && !ctrl_i.controller_addr_strobe_n
    && !ctrl_i.global_write_n |-> ##[1:2] !dq_oe_o) else $error("drive in write");
  desel_tri_a: assert property (ctrl_i.chip_sel_primary_n
    && !ctrl_i.controller_addr_strobe_n |-> ##[1:2] !dq_oe_o) else $error("drive deselected");
  sleep_in_a: assert property ((sleep_request_i && ce_i)[*8] |-> asleep_o)
    else $error("no sleep");
  sleep_out_a: assert property ((!sleep_request_i && ce_i)[*8] |-> !asleep_o)
    else $error("no wake");
  sleep_entry_a: assert property ($rose(asleep_o) |-> $past(sleep_request_i, 2))
    else $error("sleep too early");
  freeze_hold_a: assert property (!ce_i |=> $stable(dq_o) && $stable(asleep_o))
    else $error("state moved when frozen");
  cover property (sel && !ctrl_i.burst_step_n);
  cover property ($rose(asleep_o));
  cover property (dq_oe_o);
endmodule
bind pbs_sram pbs_sram_assertions chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .ctrl_i(ctrl_i), .output_en_n_i(output_en_n_i), .sleep_request_i(sleep_request_i),
  .dq_o(dq_o), .dq_oe_o(dq_oe_o), .asleep_o(asleep_o));
`default_nettype wire

// *** verif/pbs_bus_model.sv ***
// Shared data lines between the device and the bus master.
// Assumes at most one driver at a time.
`timescale 1ns/100ps
`default_nettype none
module pbs_bus_model (
  input wire logic [31:0] dev_dq_i,
  input wire logic dev_oe_i,
  input wire logic [31:0] mst_dq_i,
  input wire logic mst_oe_i,
  output logic [31:0] bus_o
);
  logic [31:0] last = 32'h0;
  // No pull on the lines, so a released bus must not show stale data
  always @*
  begin
    if (dev_oe_i)
      last = dev_dq_i;
    else if (mst_oe_i)
      last = mst_dq_i;
    bus_o = (dev_oe_i | mst_oe_i) ? last : ~last;
  end
endmodule
`default_nettype wire

// *** verif/pbs_sram_tb.sv ***
// Self-checking bench for pbs_sram.
// Assumes the bus model resolves the shared data lines.
`timescale 1ns/100ps
`default_nettype none
module pbs_sram_tb;
  logic clk = 1'h0, rst = 1'h1, ce = 1'h1, ord = 1'h1, oen = 1'h0, zz = 1'h0;
  logic mdrv = 1'h0, oe_off = 1'h0, oe, zzo;
  logic [18:0] addr = 19'h0;
  logic [31:0] mdat = 32'h0, bus, dq, exp [16];
  pbs_pkg::pbs_ctrl_t ctrl = 12'hDFF;
  int n_mismatch = 0, n_tests = 0;
  pbs_sram dut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .addr_i(addr), .ctrl_i(ctrl),
    .burst_order_i(ord), .output_en_n_i(oen), .sleep_request_i(zz), .dq_i(bus),
    .dq_o(dq), .dq_oe_o(oe), .asleep_o(zzo));
  pbs_bus_model bm (.dev_dq_i(dq), .dev_oe_i(oe), .mst_dq_i(mdat), .mst_oe_i(mdrv),
    .bus_o(bus));
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic drv(input logic [11:0] c, input logic [18:0] a, input logic [31:0] d,
    input logic w);
    @(negedge clk);
    ctrl <= c;
    addr <= a;
    mdat <= d;
    mdrv <= w;
    oen <= w | oe_off;
  endtask
  // Processor-strobe writes open with junk controls and data that must be ignored
  task automatic wr(input logic [11:0] c, input logic [18:0] a, input logic [31:0] d,
    input logic [3:0] m, input logic p);
    if (p)
      drv(12'h4EF, a, ~d, 1'h1);
    drv(c, a, d, 1'h1);
    drv(12'h5FF, a, d, 1'h0);
    for (int g = 0; g < 4; g++)
      if (m[g])
        exp[a[3:0]][8*g+:8] = d[8*g+:8];
  endtask
  task automatic rd(input logic [18:0] a);
    drv(12'h57F, a, 32'h0, 1'h0);
    drv(12'h5FF, a, 32'h0, 1'h0);
    repeat (3) @(negedge clk);
    chk(dq, exp[a[3:0]]);
  endtask
  task automatic burst(input logic o, input logic [18:0] a);
    logic [1:0] s;
    ord <= o;
    drv(12'h57F, a, 32'h0, 1'h0);
    repeat (2) drv(12'h5BF, a, 32'h0, 1'h0);
    // First word stands from the third edge; last step goes with it
    for (int k = 0; k < 4; k++)
    begin
      drv((k == 0) ? 12'h5BF : 12'h5FF, a, 32'h0, 1'h0);
      s = o ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0];
      chk(dq, exp[{a[3:2], s}]);
      if (k > 0)
        chk(oe, 1'h1);
    end
  endtask
  task automatic sleep_chk();
    drv(12'hD7F, 19'h0, 32'h0, 1'h0);
    drv(12'hDFF, 19'h0, 32'h0, 1'h0);
    chk(oe, 1'h0);
    zz <= 1'h1;
    repeat (10) @(negedge clk);
    chk(zzo, 1'h1);
    zz <= 1'h0;
    repeat (10) @(negedge clk);
    chk(zzo, 1'h0);
  endtask
  task automatic summarize();
    $display("mismatches=%0d tests=%0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    summarize();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 16; i++)
      wr(12'h56F, 19'(i), {8'hC3, 8'(i), 16'h5AA5}, 4'hF, 1'h0);
    rd(19'h3);
    rd(19'h5);
    burst(1'h1, 19'h1);
    burst(1'h0, 19'h1);
    burst(1'h1, 19'h6);
    burst(1'h0, 19'hB);
    wr(12'h55A, 19'h2, 32'h11223344, 4'h5, 1'h0);
    wr(12'h5EF, 19'h4, 32'h600DF00D, 4'hF, 1'h1);
    wr(12'h5D5, 19'h6, 32'h99887766, 4'hA, 1'h1);
    rd(19'h2);
    rd(19'h4);
    rd(19'h6);
    oe_off = 1'h1;
    rd(19'h7);
    chk(oe, 1'h0);
    oe_off = 1'h0;
    ce <= 1'h0;
    repeat (3) @(negedge clk);
    ce <= 1'h1;
    sleep_chk();
    // First read after deselect: word held off the bus for one cycle
    drv(12'h57F, 19'h4, 32'h0, 1'h0);
    drv(12'h5FF, 19'h4, 32'h0, 1'h0);
    repeat (2) @(negedge clk);
    chk(oe, 1'h0);
    @(negedge clk);
    chk(oe, 1'h1);
    chk(dq, exp[4]);
    summarize();
  end
endmodule
`default_nettype wire
